// ==== rtl/bst_map.vh ====
// Constants for the boundary-scan test logic: instruction codes, register widths,
// bus offsets and the reset time-out counts.
// Assumes inclusion by bare name from the design file.
`ifndef BST_MAP_VH
`define BST_MAP_VH

`define BST_IR_W          4
`define BST_IR_EXTEST     4'h0
`define BST_IR_IDCODE     4'h1
`define BST_IR_SAMPLE     4'h2
`define BST_IR_CORE_RST   4'hc
`define BST_IR_BYPASS     4'hf
`define BST_IR_CAPTURE    4'h1

`define BST_ID_W          32
`define BST_ID_FIXED_BIT  1'h1

`define BST_CELLS_PER_PIN 3
`define BST_CELL_DATA     0
`define BST_CELL_CTRL     1
`define BST_CELL_PUD      2

`define BST_OFS_CTRL      12'h000
`define BST_OFS_STAT      12'h004
`define BST_CTRL_DIS_BIT  0
`define BST_STAT_IR_LO    0
`define BST_STAT_CRST_BIT 4
`define BST_STAT_EN_BIT   5
`define BST_STAT_EXT_BIT  6

`define BST_TOUT_W        13
`define BST_TOUT_SEL0     13'h0000
`define BST_TOUT_SEL1     13'h0010
`define BST_TOUT_SEL2     13'h0200
`define BST_TOUT_SEL3     13'h1000

`endif

// ==== rtl/bst_tap.v ====
// Boundary-scan test logic behind a four-wire test port, with an APB slave for
// the control bit that disables the port and a read-only status word.
// Assumes the test clock, mode select and serial input arrive asynchronously and
// toggle no faster than a quarter of clk_sys; pins outside are resolved by the bench.
// Operation
// - Four-bit instruction register, sixteen codes.
// - All shift registers move LSB first.
// - Code 0x0 selects the boundary chain.
// - Chain holds pull-up, control, data, input; code keeps three cells per pin, the data cell capturing the input.
// - Extest drives latched values onto pins immediately.
// - Extest captures pins, shifts, updates outputs.
// - Code 0x1 selects ID; default after reset.
// - Idcode captures ID word then shifts it.
// - ID word fields: one, maker, part, version.
// - Version follows silicon revision, wraps at sixteen.
// - Code 0x2 samples and preloads without disturbing.
// - Sample preload latches stay off the pins.
// - Code 0xC selects reset bit, keeps TAP.
// - Reset instruction acts only in Shift-DR.
// - Core held in reset while bit is one.
// - Core stays reset for time-out after release.
// - Core reset tri-states outputs, no HIGHZ code.
// - Code 0xF selects one-stage bypass register.
// - Bypass cleared to zero leaving Capture-DR.
// - Port usable only with fuse and bit clear.
// - Runs from test clock slower than core clock.
// - Five TMS-high clocks reach Test-Logic-Reset.
// - Instruction shift outputs captured pattern 0x01.
//
// The register addresses and register access over APB were left to the implementer.
`include "bst_map.vh"

module bst_tap #(
  parameter        NPIN        = 8,       // Port pins in the boundary chain.
  parameter [3:0]  SILICON_REV = 4'h0,    // Silicon revision count.
  parameter [10:0] ID_MAKER    = 11'h2a5, // Arbitrary neutral manufacturer code.
  parameter [15:0] ID_PART     = 16'h5a3c // Arbitrary neutral part code.
) (
  input  wire             clk_sys,          // System clock, 25 MHz.
  input  wire             arst_n,           // Asynchronous reset, active low.
  input  wire             psel,             // APB select.
  input  wire             penable,          // APB access phase.
  input  wire             pwrite,           // APB direction.
  input  wire [11:0]      paddr,            // APB byte address.
  input  wire [31:0]      pwdata,           // APB write data.
  output wire             pready,           // APB ready.
  output reg  [31:0]      prdata,           // APB read data.
  output wire             pslverr,          // APB error on unmapped address.
  input  wire             tck,              // Test clock pin.
  input  wire             tms,              // Test mode select pin.
  input  wire             tdi,              // Test serial input pin.
  output reg              tdo,              // Test serial output.
  output reg              tdo_oe,           // Serial output enable, high drives.
  input  wire             test_port_enable_fuse, // Enable fuse, high when programmed.
  input  wire [1:0]       tout_sel,         // Clock-option time-out select.
  input  wire             ext_rst_n,        // External reset request, active low.
  output wire             core_rst_n,       // Core reset, active low.
  input  wire [NPIN-1:0]  pin_in,           // Levels seen on the pins.
  input  wire [NPIN-1:0]  core_do,          // Core output data.
  input  wire [NPIN-1:0]  core_oe,          // Core output control.
  input  wire [NPIN-1:0]  core_pud,         // Core pull-up disable.
  output reg  [NPIN-1:0]  pin_do,           // Pin output data.
  output reg  [NPIN-1:0]  pin_oe,           // Pin output enable.
  output reg  [NPIN-1:0]  pin_pud           // Pin pull-up disable.
);

  localparam CHW = NPIN * `BST_CELLS_PER_PIN;

  localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDR = 16'h0004, S_CDR = 16'h0008,
                    S_SHD = 16'h0010, S_E1D = 16'h0020, S_PDR = 16'h0040, S_E2D = 16'h0080,
                    S_UDR = 16'h0100, S_SIR = 16'h0200, S_CIR = 16'h0400, S_SHI = 16'h0800,
                    S_E1I = 16'h1000, S_PIR = 16'h2000, S_E2I = 16'h4000, S_UIR = 16'h8000;

  function [15:0] tap_next;
    input [15:0] s;
    input        m;
    begin
      case (s)
        S_TLR: tap_next = m ? S_TLR : S_RTI;
        S_RTI: tap_next = m ? S_SDR : S_RTI;
        S_SDR: tap_next = m ? S_SIR : S_CDR;
        S_CDR: tap_next = m ? S_E1D : S_SHD;
        S_SHD: tap_next = m ? S_E1D : S_SHD;
        S_E1D: tap_next = m ? S_UDR : S_PDR;
        S_PDR: tap_next = m ? S_E2D : S_PDR;
        S_E2D: tap_next = m ? S_UDR : S_SHD;
        S_UDR: tap_next = m ? S_SDR : S_RTI;
        S_SIR: tap_next = m ? S_TLR : S_CIR;
        S_CIR: tap_next = m ? S_E1I : S_SHI;
        S_SHI: tap_next = m ? S_E1I : S_SHI;
        S_E1I: tap_next = m ? S_UIR : S_PIR;
        S_PIR: tap_next = m ? S_E2I : S_PIR;
        S_E2I: tap_next = m ? S_UIR : S_SHI;
        S_UIR: tap_next = m ? S_SDR : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  function [`BST_TOUT_W-1:0] tout_count;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    tout_count = `BST_TOUT_SEL0;
        2'h1:    tout_count = `BST_TOUT_SEL1;
        2'h2:    tout_count = `BST_TOUT_SEL2;
        default: tout_count = `BST_TOUT_SEL3;
      endcase
    end
  endfunction

  reg                   tck_s1_q, tck_s2_q, tck_s3_q;
  reg                   tms_s1_q, tms_s2_q;
  reg                   tdi_s1_q, tdi_s2_q;
  reg                   fuse_s1_q, fuse_s2_q;
  reg                   ext_s1_q, ext_s2_q;
  reg  [NPIN-1:0]       pin_s1_q, pin_s2_q;
  reg                   dis_q;
  reg  [15:0]           st_q;
  reg  [`BST_IR_W-1:0]  ir_sh_q, ir_q;
  reg                   byp_q;
  reg  [`BST_ID_W-1:0]  id_sh_q;
  reg                   rst_q;
  reg  [CHW-1:0]        ch_sh_q, ch_lat_q;
  reg  [`BST_TOUT_W-1:0] tout_q;
  reg  [CHW-1:0]        ch_cap;
  reg                   sdo;
  integer               i;
  integer               j;

  wire tck_rise = tck_s2_q & ~tck_s3_q;
  wire tck_fall = ~tck_s2_q & tck_s3_q;

  wire port_en = fuse_s2_q & ~dis_q;

  wire [`BST_ID_W-1:0] id_word = {SILICON_REV, ID_PART, ID_MAKER, `BST_ID_FIXED_BIT};

  wire sel_ext = (ir_q == `BST_IR_EXTEST);
  wire sel_chain = sel_ext | (ir_q == `BST_IR_SAMPLE);
  wire sel_id  = (ir_q == `BST_IR_IDCODE);
  wire sel_rst = (ir_q == `BST_IR_CORE_RST);
  wire sel_byp = ~(sel_chain | sel_id | sel_rst);

  wire core_in_reset = rst_q | ~ext_s2_q | (tout_q != {`BST_TOUT_W{1'b0}});

  assign core_rst_n = ~core_in_reset;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & (paddr != `BST_OFS_CTRL) & (paddr != `BST_OFS_STAT);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_s3_q <= 1'b0;
      tms_s1_q <= 1'b1;
      tms_s2_q <= 1'b1;
      tdi_s1_q <= 1'b1;
      tdi_s2_q <= 1'b1;
      fuse_s1_q <= 1'b0;
      fuse_s2_q <= 1'b0;
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      pin_s1_q <= {NPIN{1'b0}};
      pin_s2_q <= {NPIN{1'b0}};
    end else begin
      tck_s1_q <= tck;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
      tms_s1_q <= tms;
      tms_s2_q <= tms_s1_q;
      tdi_s1_q <= tdi;
      tdi_s2_q <= tdi_s1_q;
      // Fuse, reset request and pin levels come from outside as well, so they are synchronised too.
      fuse_s1_q <= test_port_enable_fuse;
      fuse_s2_q <= fuse_s1_q;
      ext_s1_q <= ext_rst_n;
      ext_s2_q <= ext_s1_q;
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  always @* begin
    ch_cap = {CHW{1'b0}};
    for (j = 0; j < NPIN; j = j + 1) begin
      ch_cap[j*`BST_CELLS_PER_PIN + `BST_CELL_DATA] = pin_s2_q[j];
      ch_cap[j*`BST_CELLS_PER_PIN + `BST_CELL_CTRL] = core_oe[j];
      ch_cap[j*`BST_CELLS_PER_PIN + `BST_CELL_PUD]  = core_pud[j];
    end
  end

  always @* begin
    if (st_q == S_SHI)
      sdo = ir_sh_q[0];
    else if (sel_chain)
      sdo = ch_sh_q[0];
    else if (sel_id)
      sdo = id_sh_q[0];
    else if (sel_rst)
      sdo = rst_q;
    else
      sdo = byp_q;
  end

  // The TAP and every scan register act on the sampled rising edge of the test clock.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q     <= S_TLR;
      ir_sh_q  <= `BST_IR_CAPTURE;
      ir_q     <= `BST_IR_IDCODE;
      byp_q    <= 1'b0;
      id_sh_q  <= {`BST_ID_W{1'b0}};
      rst_q    <= 1'b0;
      ch_sh_q  <= {CHW{1'b0}};
      ch_lat_q <= {CHW{1'b0}};
    end else if (!port_en) begin
      st_q <= S_TLR;
      ir_q <= `BST_IR_IDCODE;
    end else if (tck_rise) begin
      st_q <= tap_next(st_q, tms_s2_q);
      case (st_q)
        S_TLR: ir_q <= `BST_IR_IDCODE;
        S_CIR: ir_sh_q <= `BST_IR_CAPTURE;
        S_SHI: ir_sh_q <= {tdi_s2_q, ir_sh_q[`BST_IR_W-1:1]};
        S_UIR: ir_q <= ir_sh_q;
        S_CDR: begin
          if (sel_byp)
            byp_q <= 1'b0;
          if (sel_id)
            id_sh_q <= id_word;
          if (sel_chain)
            ch_sh_q <= ch_cap;
        end
        S_SHD: begin
          if (sel_byp)
            byp_q <= tdi_s2_q;
          if (sel_id)
            id_sh_q <= {tdi_s2_q, id_sh_q[`BST_ID_W-1:1]};
          if (sel_rst)
            rst_q <= tdi_s2_q;
          if (sel_chain)
            ch_sh_q <= {tdi_s2_q, ch_sh_q[CHW-1:1]};
        end
        S_UDR: begin
          if (sel_chain)
            ch_lat_q <= ch_sh_q;
        end
        default: ;
      endcase
    end
  end

  // The serial output changes on the falling test clock edge, half a period ahead of sampling.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!port_en) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= sdo;
      tdo_oe <= (st_q == S_SHD) | (st_q == S_SHI);
    end
  end

  // The time-out reloads while any reset source is active and counts down after release.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tout_q <= {`BST_TOUT_W{1'b0}};
    end else if (rst_q | ~ext_s2_q) begin
      tout_q <= tout_count(tout_sel);
    end else if (tout_q != {`BST_TOUT_W{1'b0}}) begin
      tout_q <= tout_q - {{(`BST_TOUT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_do  <= {NPIN{1'b0}};
      pin_oe  <= {NPIN{1'b0}};
      pin_pud <= {NPIN{1'b0}};
    end else begin
      for (i = 0; i < NPIN; i = i + 1) begin
        if (sel_ext && port_en) begin
          pin_do[i]  <= ch_lat_q[i*`BST_CELLS_PER_PIN + `BST_CELL_DATA];
          pin_oe[i]  <= ch_lat_q[i*`BST_CELLS_PER_PIN + `BST_CELL_CTRL];
          pin_pud[i] <= ch_lat_q[i*`BST_CELLS_PER_PIN + `BST_CELL_PUD];
        end else begin
          pin_do[i]  <= core_do[i];
          pin_oe[i]  <= core_oe[i] & ~core_in_reset;
          pin_pud[i] <= core_pud[i] | core_in_reset;
        end
      end
    end
  end

  // Writes land on the access edge; only the disable bit is writable.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dis_q <= 1'b0;
    end else if (psel && penable && pwrite && paddr == `BST_OFS_CTRL) begin
      dis_q <= pwdata[`BST_CTRL_DIS_BIT];
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (paddr == `BST_OFS_CTRL)
        prdata[`BST_CTRL_DIS_BIT] <= dis_q;
      else if (paddr == `BST_OFS_STAT) begin
        prdata[`BST_STAT_IR_LO +: `BST_IR_W] <= ir_q;
        prdata[`BST_STAT_CRST_BIT] <= core_in_reset;
        prdata[`BST_STAT_EN_BIT]   <= port_en;
        prdata[`BST_STAT_EXT_BIT]  <= sel_ext;
      end
    end
  end

endmodule

// ==== sim/bst_tap_checker.sv ====
// Port assertions for the boundary-scan block.
// Assumes one clk_sys domain; bound onto bst_tap below.
module bst_tap_checker (
  input wire        clk_sys,               // System clock.
  input wire        arst_n,                // Reset, active low.
  input wire        psel,                  // APB select.
  input wire        penable,               // APB access phase.
  input wire        pwrite,                // APB direction.
  input wire [11:0] paddr,                 // APB address.
  input wire [31:0] prdata,                // APB read data.
  input wire        pready,                // APB ready.
  input wire        pslverr,               // APB error.
  input wire        tdo_oe,                // Serial output enable.
  input wire        test_port_enable_fuse, // Enable fuse.
  input wire [1:0]  tout_sel,              // Time-out select.
  input wire        ext_rst_n,             // External reset request.
  input wire        core_rst_n             // Core reset.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire unm = (paddr != 12'h000) && (paddr != 12'h004);
  sequence s_release;
    $rose(core_rst_n) ##0 (tout_sel == 2'h2);
  endsequence
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && unm |-> pslverr) else $error("no pslverr");
  a_err_mapped: assert property (psel && penable && !unm |-> !pslverr) else $error("bad pslverr");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
  a_rdata_unmapped: assert property (psel && !penable && !pwrite && unm |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_ext_reset: assert property (!ext_rst_n ##1 !ext_rst_n |=> !core_rst_n) else $error("core not in reset");
  a_fuse_idle: assert property ((!test_port_enable_fuse) [*4] |-> !tdo_oe) else $error("tdo driven");
  a_tout_hold: assert property (s_release |-> !$past(core_rst_n, 256)) else $error("time-out short");
endmodule

bind bst_tap bst_tap_checker chk_u (
  .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tdo_oe(tdo_oe),
  .test_port_enable_fuse(test_port_enable_fuse), .tout_sel(tout_sel), .ext_rst_n(ext_rst_n),
  .core_rst_n(core_rst_n)
);

// ==== sim/bst_ctl_model.sv ====
// Board-test controller model driving the four-wire test port.
// Assumes clk_sys at 40 ns; the test clock is paced at 320 ns from it.
module bst_ctl_model (
  input  wire logic clk_sys, // Pacing clock.
  input  wire logic tdo,     // Serial data from the device.
  input  wire logic tdo_oe,  // Device drives tdo while high.
  output logic      tck,     // Test clock, still between frames.
  output logic      tms,     // Mode select.
  output logic      tdi      // Serial data to the device.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clk_sys);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge clk_sys);
    o = tdo_oe ? tdo : 1'bz;
    tck <= 1'b1;
    repeat (4) @(posedge clk_sys);
    tck <= 1'b0;
  endtask
  task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  task automatic tlr();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule

// ==== sim/bst_tap_tb.sv ====
// Self-checking bench for the boundary-scan block.
// Assumes the controller model and the bound checker are compiled alongside.
module bst_tap_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID = {4'h3, 16'h1234, 11'h155, 1'b1};
  logic        clk_sys, arst_n, psel, penable, pwrite, fuse, ext_rst_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, d;
  logic [1:0]  tout_sel;
  logic [7:0]  pin_in, core_do, core_oe, core_pud;
  logic        er, o;
  wire         pready, pslverr, tdo, tdo_oe, core_rst_n, tck, tms, tdi;
  wire  [31:0] prdata;
  wire  [7:0]  pin_do, pin_oe, pin_pud;
  int          n_errors, n_tests, k;
  bst_tap #(.NPIN(8), .SILICON_REV(4'h3), .ID_MAKER(11'h155), .ID_PART(16'h1234)) dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .test_port_enable_fuse(fuse),
    .tout_sel(tout_sel), .ext_rst_n(ext_rst_n), .core_rst_n(core_rst_n), .pin_in(pin_in),
    .core_do(core_do), .core_oe(core_oe), .core_pud(core_pud), .pin_do(pin_do),
    .pin_oe(pin_oe), .pin_pud(pin_pud));
  bst_ctl_model ctl_u (.clk_sys(clk_sys), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      n_errors++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  function automatic logic [31:0] cap();
    cap = 32'h0;
    for (int i = 0; i < 8; i++) cap[3*i +: 3] = {core_pud[i], core_oe[i], pin_in[i]};
  endfunction
  task t_regs();
    apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h21, "status after reset");
    apb(1'b0, 12'h008, 32'h0); chk({rd[30:0], er}, 32'h1, "unmapped read");
  endtask
  task t_idcode();
    ctl_u.scan(1'b1, 32'h1, 4, d); chk(d, 32'h1, "ir capture");
    ctl_u.scan(1'b0, 32'h0, 32, d); chk(d, ID, "id word");
  endtask
  task t_bypass();
    logic [3:0] codes [3] = '{4'hf, 4'h5, 4'h9};
    foreach (codes[j]) begin
      ctl_u.scan(1'b1, {28'h0, codes[j]}, 4, d);
      ctl_u.scan(1'b0, 32'h3, 2, d); chk(d, 32'h2, "bypass path");
    end
  endtask
  task t_sample_extest();
    ctl_u.scan(1'b1, 32'h2, 4, d);
    ctl_u.scan(1'b0, 32'h00a5c3, 24, d); chk(d, cap(), "sample capture");
    chk({pin_do, pin_oe, pin_pud}, {core_do, core_oe, core_pud}, "sample pins");
    ctl_u.scan(1'b1, 32'h0, 4, d);
    // Pins move one clk_sys after the update edge, which is the scan's last edge.
    repeat (2) @(posedge clk_sys);
    chk({pin_pud, pin_oe, pin_do}, {8'h04, 8'h1d, 8'h25}, "extest latched");
    apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h60, "extest status");
    pin_in <= 8'h3c;
    ctl_u.scan(1'b0, 32'h924924, 24, d); chk(d, cap(), "extest capture");
    repeat (2) @(posedge clk_sys);
    chk({pin_pud, pin_oe, pin_do}, {8'hff, 8'h00, 8'h00}, "extest update");
  endtask
  task t_core_reset();
    tout_sel <= 2'h2;
    ctl_u.scan(1'b1, 32'hc, 4, d);
    ctl_u.scan(1'b0, 32'h1, 1, d); chk(core_rst_n, 1'b0, "reset bit set");
    chk({pin_oe, pin_pud}, 16'h00ff, "pins tri-stated");
    ctl_u.scan(1'b0, 32'h0, 1, d); chk(core_rst_n, 1'b0, "time-out hold");
    for (k = 0; k < 600 && core_rst_n !== 1'b1; k++) @(posedge clk_sys);
    chk(core_rst_n, 1'b1, "core released");
    ctl_u.scan(1'b1, 32'hf, 4, d);
    ctl_u.tlr();
    ctl_u.scan(1'b0, 32'h0, 32, d); chk(d, ID, "tms reset to idcode");
  endtask
  task t_disable();
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h1, "control readback");
    apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h01, "disabled status");
    ctl_u.scan(1'b1, 32'hf, 4, d); chk(d, {28'h0, 4'hz}, "disabled tdo");
    apb(1'b1, 12'h000, 32'h0);
    fuse <= 1'b0;
    repeat (6) @(posedge clk_sys);
    apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h01, "fuse off status");
    fuse <= 1'b1;
    ext_rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(core_rst_n, 1'b0, "external reset");
    ext_rst_n <= 1'b1;
    ctl_u.step(1'b0, 1'b0, o);
    ctl_u.scan(1'b0, 32'h0, 32, d); chk(d, ID, "idcode after enable");
  endtask
  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    fuse = 1'b1; ext_rst_n = 1'b1; tout_sel = 2'h0; pin_in = 8'h5a; core_do = 8'h96;
    core_oe = 8'hc3; core_pud = 8'h0f; n_errors = 0; n_tests = 0;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ctl_u.step(1'b0, 1'b0, o);
    t_regs();
    t_idcode();
    t_bypass();
    t_sample_extest();
    t_core_reset();
    t_disable();
    print_verdict();
  end
endmodule
